// ==== design/sasd_datapath.sv ====
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module sasd_datapath
  import sasd_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int MEM_AW = 8
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // sequencer issue
  input  wire logic               instr_valid,
  input  wire logic [2:0]         instr_op,
  input  wire logic [BITSEL_W-1:0] instr_bit,
  input  wire logic [MEM_AW-1:0]  instr_addr,
  output logic                    instr_ready,
  output logic                    instr_done,
  output logic                    skip_dummy,
  // data memory
  input  wire logic [DATA_W-1:0]  mem_rdata,
  output logic                    mem_wr,
  output logic      [MEM_AW-1:0]  mem_waddr,
  output logic      [DATA_W-1:0]  mem_wdata,
  // core state
  output logic      [DATA_W-1:0]  working_register,
  output logic      [FLAGS_W-1:0] status_flags
);

  // widened first so the upper-bit test stays legal when ADDR_W is exactly 8
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [31:0] wide;
    logic [7:0]  lo;
    wide        = 32'(a);
    lo          = wide[7:0];
    addr_mapped = (wide[31:8] == 24'h00_0000) &&
                  (lo == ADDR_ACC || lo == ADDR_FLAGS || lo == ADDR_STATUS || lo == ADDR_SKIPS);
  endfunction : addr_mapped

  sasd_state_t            state_q;
  logic [DATA_W-1:0]      acc_q;
  logic [FLAGS_W-1:0]     flags_q;
  logic                   done_q;
  logic                   last_skip_q;
  logic [15:0]            skips_q;
  logic                   mem_wr_q;
  logic [MEM_AW-1:0]      mem_waddr_q;
  logic [DATA_W-1:0]      mem_wdata_q;
  logic [31:0]            prdata_q;

  logic                   accept;
  logic                   skip_d;
  logic [DATA_W-1:0]      inc_val;
  logic [DATA_W-1:0]      sub_diff;
  logic [FLAGS_W-1:0]     sub_flags;
  logic                   apb_wr;
  logic [7:0]             reg_sel;

  assign instr_ready      = (state_q == ST_RUN);
  assign accept           = instr_valid && instr_ready;
  assign skip_dummy       = (state_q == ST_DUMMY);
  assign instr_done       = done_q;
  assign mem_wr           = mem_wr_q;
  assign mem_waddr        = mem_waddr_q;
  assign mem_wdata        = mem_wdata_q;
  assign working_register = acc_q;
  assign status_flags     = flags_q;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign prdata  = prdata_q;
  assign apb_wr  = psel && penable && pwrite && addr_mapped(paddr);
  assign reg_sel = paddr[7:0];

  assign inc_val = 8'(mem_rdata + 8'h01);

  sasd_sub_unit u_sub (
    .minuend    (acc_q),
    .subtrahend (mem_rdata),
    .diff       (sub_diff),
    .flags      (sub_flags)
  );

  always_comb begin
    case (sasd_op_t'(instr_op))
      OP_INCR_TO_ACCUM_SKIP_IF_NIL: skip_d = (inc_val == 8'h00);
      OP_SKIP_IF_NONNULL_BIT:       skip_d = mem_rdata[instr_bit];
      OP_SKIP_IF_NONNULL_BYTE:      skip_d = (mem_rdata != 8'h00);
      default:                      skip_d = 1'b0;
    endcase
  end

  // one dummy cycle after a skipping instruction; issue is held off meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN:   state_q <= (accept && skip_d) ? ST_DUMMY : ST_RUN;
        ST_DUMMY: state_q <= ST_RUN;
        default:  state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q      <= 1'b0;
      last_skip_q <= 1'b0;
      skips_q     <= SKIPS_RST;
    end else begin
      done_q <= accept;
      if (accept) begin
        last_skip_q <= skip_d;
      end
      if (accept && skip_d) begin
        skips_q <= 16'(skips_q + 16'h0001);
      end
    end
  end

  // the instruction wins over a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= ACC_RST;
    end else if (accept && sasd_op_t'(instr_op) == OP_INCR_TO_ACCUM_SKIP_IF_NIL) begin
      acc_q <= inc_val;
    end else if (accept && sasd_op_t'(instr_op) == OP_SUB_MEM) begin
      acc_q <= sub_diff;
    end else if (apb_wr && reg_sel == ADDR_ACC) begin
      acc_q <= pwdata[DATA_W-1:0];
    end
  end

  // only the subtract and a software write touch flags; skip forms fall through unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= FLAGS_RST;
    end else if (accept && sasd_op_t'(instr_op) == OP_SUB_MEM) begin
      flags_q <= sub_flags;
    end else if (apb_wr && reg_sel == ADDR_FLAGS) begin
      flags_q <= pwdata[FLAGS_W-1:0];
    end
  end

  // write-back of the byte test; increment-skip never writes memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr_q    <= 1'b0;
      mem_waddr_q <= '0;
      mem_wdata_q <= '0;
    end else begin
      mem_wr_q <= accept && sasd_op_t'(instr_op) == OP_SKIP_IF_NONNULL_BYTE;
      if (accept && sasd_op_t'(instr_op) == OP_SKIP_IF_NONNULL_BYTE) begin
        mem_waddr_q <= instr_addr;
        mem_wdata_q <= mem_rdata;
      end
    end
  end

  // read data captured in the setup phase, so it is ready in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (addr_mapped(paddr)) begin
        case (reg_sel)
          ADDR_ACC:    prdata_q <= {24'h00_0000, acc_q};
          ADDR_FLAGS:  prdata_q <= {26'h000_0000, flags_q};
          ADDR_STATUS: prdata_q <= {30'h0000_0000, last_skip_q, (state_q == ST_DUMMY)};
          ADDR_SKIPS:  prdata_q <= {16'h0000, skips_q};
          default:     prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic is_inc;
  logic is_bit;
  logic is_byte;
  logic is_sub;
  assign is_inc  = accept && sasd_op_t'(instr_op) == OP_INCR_TO_ACCUM_SKIP_IF_NIL;
  assign is_bit  = accept && sasd_op_t'(instr_op) == OP_SKIP_IF_NONNULL_BIT;
  assign is_byte = accept && sasd_op_t'(instr_op) == OP_SKIP_IF_NONNULL_BYTE;
  assign is_sub  = accept && sasd_op_t'(instr_op) == OP_SUB_MEM;

  // operand copies for the checks, taken every edge
  logic [DATA_W-1:0]   chk_acc_q;
  logic [DATA_W-1:0]   chk_mem_q;
  logic [BITSEL_W-1:0] chk_bit_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_acc_q <= '0;
      chk_mem_q <= '0;
      chk_bit_q <= '0;
    end else begin
      chk_acc_q <= acc_q;
      chk_mem_q <= mem_rdata;
      chk_bit_q <= instr_bit;
    end
  end

  a_inc_acc_load: assert property (is_inc |=> acc_q == 8'($past(mem_rdata) + 8'h01))
    else $error("increment-skip did not load byte plus one");

  a_inc_no_write: assert property (is_inc |=> !mem_wr)
    else $error("increment-skip wrote data memory");

  a_inc_skip_zero: assert property (is_inc |=> skip_dummy == (acc_q == 8'h00))
    else $error("increment-skip skip decision wrong");

  a_dummy_one_cycle: assert property (accept && skip_d |=> skip_dummy && !instr_ready ##1 instr_ready)
    else $error("dummy cycle not exactly one cycle");

  a_no_skip_no_dummy: assert property (accept && !skip_d |=> !skip_dummy)
    else $error("dummy cycle without a skip");

  a_bit_skip: assert property (is_bit |=> skip_dummy == chk_mem_q[chk_bit_q])
    else $error("bit test skip decision wrong");

  a_byte_wback: assert property (is_byte |=> mem_wr && mem_wdata == $past(mem_rdata)
                                  && mem_waddr == $past(instr_addr) ##1 mem_wr == $past(is_byte))
    else $error("byte test write-back wrong");

  a_byte_skip: assert property (is_byte |=> skip_dummy == ($past(mem_rdata) != 8'h00))
    else $error("byte test skip decision wrong");

  a_sub_result: assert property (is_sub |=> acc_q == 8'($past(acc_q) - $past(mem_rdata)))
    else $error("subtract result wrong");

  a_sub_carry: assert property (is_sub |=> flags_q[FLG_CARRY] == ($past(acc_q) >= $past(mem_rdata)))
    else $error("subtract carry wrong");

  a_sub_zero_flags: assert property (is_sub |=> flags_q[FLG_ZERO] == (acc_q == 8'h00)
                                      && flags_q[FLG_CHAIN_NUL] == (acc_q == 8'h00))
    else $error("subtract zero flags wrong");

  a_sub_half_brw: assert property (is_sub |=> flags_q[FLG_HALF_BRW] == (chk_acc_q[3:0] >= chk_mem_q[3:0]))
    else $error("subtract half-borrow flag wrong");

  a_sub_signed_ov: assert property (is_sub |=> flags_q[FLG_SIGNED_OV] ==
                                     ((chk_acc_q[DATA_W-1] != chk_mem_q[DATA_W-1]) && (acc_q[DATA_W-1] != chk_acc_q[DATA_W-1])))
    else $error("subtract overflow flag wrong");

  a_sub_sign_brw: assert property (is_sub |=> flags_q[FLG_SIGN_BRW] == ($signed(chk_acc_q) >= $signed(chk_mem_q)))
    else $error("subtract signed-borrow flag wrong");

  a_skip_flags_kept: assert property ((is_inc || is_bit || is_byte) && !(apb_wr && reg_sel == ADDR_FLAGS)
                                      |=> $stable(flags_q))
    else $error("skip instruction changed flags");

  a_dummy_no_issue: assert property (skip_dummy |=> !instr_done)
    else $error("instruction taken in dummy cycle");

  a_dummy_single: assert property (skip_dummy |=> !skip_dummy)
    else $error("dummy cycle repeated");

  a_sub_no_write: assert property (is_sub |=> !mem_wr)
    else $error("subtract wrote data memory");

  a_bit_no_write: assert property (is_bit |=> !mem_wr)
    else $error("bit test wrote data memory");

  a_skip_acc_kept: assert property ((is_bit || is_byte) && !(apb_wr && reg_sel == ADDR_ACC) |=> $stable(acc_q))
    else $error("not-zero test changed working register");

  a_nop_kept: assert property (accept && sasd_op_t'(instr_op) == OP_NONE && !apb_wr
                               |=> $stable(acc_q) && $stable(flags_q) && !mem_wr && !skip_dummy)
    else $error("no-op changed state");

  a_done_follows: assert property (1'b1 |=> instr_done == $past(accept))
    else $error("done pulse not one cycle after acceptance");

  a_skips_count: assert property (accept && skip_d |=> skips_q == 16'($past(skips_q) + 16'h0001))
    else $error("skip count not advanced");

  a_read_acc: assert property (psel && !penable && !pwrite && paddr == ADDR_ACC |=> prdata == {24'h00_0000, $past(acc_q)})
    else $error("working register read data wrong");

  c_inc_skip:  cover property (is_inc && skip_d ##1 skip_dummy);
  c_bit_skip:  cover property (is_bit && skip_d ##2 instr_ready);
  c_byte_wb:   cover property (is_byte ##1 mem_wr);
  c_sub_neg:   cover property (is_sub ##1 !flags_q[FLG_CARRY]);
  c_sub_ovf:   cover property (is_sub ##1 flags_q[FLG_SIGNED_OV]);

endmodule : sasd_datapath

// ==== design/sasd_pkg.sv ====
package sasd_pkg;

  // datapath widths
  localparam int DATA_W   = 8;
  localparam int FLAGS_W  = 6;
  localparam int BITSEL_W = 3;

  // instruction codes presented by the sequencer
  typedef enum logic [2:0] {
    OP_NONE                           = 3'h0,
    OP_INCR_TO_ACCUM_SKIP_IF_NIL      = 3'h1,
    OP_SKIP_IF_NONNULL_BIT            = 3'h2,
    OP_SKIP_IF_NONNULL_BYTE           = 3'h3,
    OP_SUB_MEM                        = 3'h4
  } sasd_op_t;

  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_DUMMY = 1'b1
  } sasd_state_t;

  // status flag field positions
  localparam int FLG_CARRY     = 0;
  localparam int FLG_HALF_BRW  = 1;
  localparam int FLG_ZERO      = 2;
  localparam int FLG_SIGNED_OV = 3;
  localparam int FLG_SIGN_BRW  = 4;
  localparam int FLG_CHAIN_NUL = 5;

  // register map, byte addresses
  localparam logic [7:0] ADDR_ACC    = 8'h00;
  localparam logic [7:0] ADDR_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SKIPS  = 8'h0C;

  // status register fields
  localparam int STS_BUSY      = 0;
  localparam int STS_LAST_SKIP = 1;

  // reset values
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [15:0]        SKIPS_RST = 16'h0000;

endpackage : sasd_pkg

// ==== design/sasd_sub_unit.sv ====
`timescale 1ns/1ps
module sasd_sub_unit
  import sasd_pkg::*;
(
  // operands
  input  wire logic [DATA_W-1:0]  minuend,
  input  wire logic [DATA_W-1:0]  subtrahend,
  // result
  output logic      [DATA_W-1:0]  diff,
  output logic      [FLAGS_W-1:0] flags
);

  logic [DATA_W:0] full;
  logic [4:0]      low_nib;
  logic            ovf;

  always_comb begin
    full    = {1'b0, minuend} - {1'b0, subtrahend};
    low_nib = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    diff    = full[DATA_W-1:0];
    ovf     = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ diff[7]);
    flags   = '0;
    // carry means no borrow: cleared only on a negative difference
    flags[FLG_CARRY]     = ~full[DATA_W];
    flags[FLG_HALF_BRW]  = ~low_nib[4];
    flags[FLG_ZERO]      = (diff == 8'h00);
    flags[FLG_SIGNED_OV] = ovf;
    // set when the signed minuend is not below the subtrahend
    flags[FLG_SIGN_BRW]  = ~(diff[7] ^ ovf);
    // single-byte subtract has no chain, so it follows zero
    flags[FLG_CHAIN_NUL] = (diff == 8'h00);
  end

endmodule : sasd_sub_unit

// ==== test/sasd_datapath_tb_top.sv ====
`timescale 1ns/1ps
module sasd_datapath_tb_top;
  import sasd_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, r;
  logic                instr_valid, instr_ready, instr_done, skip_dummy, mem_wr, e;
  logic [2:0]          instr_op;
  logic [BITSEL_W-1:0] instr_bit;
  logic [7:0]          instr_addr, mem_rdata, mem_waddr, mem_wdata, working_register, a, m;
  logic [FLAGS_W-1:0]  status_flags;
  int                  error_cnt, samples_checked, skip_cnt;

  sasd_datapath sasd_datapath_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_bit(instr_bit), .instr_addr(instr_addr),
    .instr_ready(instr_ready), .instr_done(instr_done), .skip_dummy(skip_dummy), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .working_register(working_register),
    .status_flags(status_flags));

  always #2.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // issue one instruction, then watch the following cycle for the dummy slot
  task automatic issue(input sasd_op_t op, input logic [2:0] b, input logic [7:0] ad, input logic [7:0] d,
                       input logic sk);
    logic wb;
    wb = (op == OP_SKIP_IF_NONNULL_BYTE);
    if (sk) begin
      skip_cnt++;
    end
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_bit   <= b;
    instr_addr  <= ad;
    mem_rdata   <= d;
    @(posedge pclk);
    instr_valid <= 1'b0;
    mem_rdata   <= ~d;
    #1;
    chk(instr_done, 1'b1);
    chk(skip_dummy, sk);
    chk(instr_ready, !sk);
    chk(mem_wr, wb);
    if (wb) begin
      chk(mem_waddr, ad);
      chk(mem_wdata, d);
    end
    @(posedge pclk);
    #1;
    chk(skip_dummy, 1'b0);
    chk(instr_ready, 1'b1);
  endtask : issue

  task automatic t_apb();
    chk(working_register, ACC_RST);
    chk(status_flags, FLAGS_RST);
    apb(1'b1, ADDR_ACC, 32'h0000_00A5);
    apb(1'b0, ADDR_ACC, 32'h0);
    chk(r, 32'h0000_00A5);
    chk(e, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    $display("apb test done");
  endtask : t_apb

  task automatic t_incr();
    logic [7:0] v [3] = '{8'hFF, 8'h00, 8'h7F};
    foreach (v[i]) begin
      issue(OP_INCR_TO_ACCUM_SKIP_IF_NIL, 3'h0, 8'(8'h20 + i), v[i], 8'(v[i] + 8'h01) == 8'h00);
      chk(working_register, 8'(v[i] + 8'h01));
    end
    $display("increment skip test done");
  endtask : t_incr

  task automatic t_bits();
    for (int i = 0; i < 8; i++) begin
      issue(OP_SKIP_IF_NONNULL_BIT, i[2:0], 8'h30, 8'h01 << i, 1'b1);
      issue(OP_SKIP_IF_NONNULL_BIT, i[2:0], 8'h31, ~(8'h01 << i), 1'b0);
    end
    $display("bit test done");
  endtask : t_bits

  task automatic t_byte();
    issue(OP_SKIP_IF_NONNULL_BYTE, 3'h0, 8'h40, 8'h00, 1'b0);
    issue(OP_SKIP_IF_NONNULL_BYTE, 3'h0, 8'hFE, 8'h5A, 1'b1);
    issue(OP_SKIP_IF_NONNULL_BYTE, 3'h0, 8'h01, 8'h80, 1'b1);
    $display("byte test done");
  endtask : t_byte

  task automatic t_sub();
    logic [15:0]        v [5] = '{16'h0507, 16'h0707, 16'h8001, 16'h3C0F, 16'h7F80};
    logic [FLAGS_W-1:0] f;
    foreach (v[i]) begin
      {a, m} = v[i];
      apb(1'b1, ADDR_ACC, {24'h0, a});
      issue(OP_SUB_MEM, 3'h0, 8'h50, m, 1'b0);
      f[FLG_CARRY]     = a >= m;
      f[FLG_HALF_BRW]  = a[3:0] >= m[3:0];
      f[FLG_ZERO]      = a == m;
      f[FLG_SIGNED_OV] = (a[7] != m[7]) && (((a - m) >> 7) != a[7]);
      f[FLG_SIGN_BRW]  = $signed(a) >= $signed(m);
      f[FLG_CHAIN_NUL] = a == m;
      chk(working_register, 8'(a - m));
      chk(status_flags[FLG_CARRY], a >= m);
      chk(status_flags, f);
    end
    $display("subtract test done");
  endtask : t_sub

  task automatic t_flags();
    apb(1'b1, ADDR_FLAGS, 32'h0000_003F);
    issue(OP_INCR_TO_ACCUM_SKIP_IF_NIL, 3'h0, 8'h60, 8'hFF, 1'b1);
    chk(status_flags, 6'h3F);
    apb(1'b1, ADDR_FLAGS, 32'h0000_002A);
    issue(OP_SKIP_IF_NONNULL_BIT, 3'h7, 8'h61, 8'h80, 1'b1);
    chk(status_flags, 6'h2A);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'h0000_0002);
    issue(OP_SKIP_IF_NONNULL_BYTE, 3'h0, 8'h62, 8'h00, 1'b0);
    chk(status_flags, 6'h2A);
    issue(OP_NONE, 3'h0, 8'h63, 8'h00, 1'b0);
    chk(working_register, 8'h00);
    chk(status_flags, 6'h2A);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk(r, 32'h0000_002A);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'h0000_0000);
    apb(1'b0, ADDR_SKIPS, 32'h0);
    chk(r, skip_cnt);
    $display("flag hold test done");
  endtask : t_flags

  // reset in mid-run, then an instruction right after release
  task automatic t_rst();
    apb(1'b1, ADDR_ACC, 32'h0000_0033);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk(working_register, ACC_RST);
    chk(status_flags, FLAGS_RST);
    chk(instr_ready, 1'b1);
    chk(instr_done, 1'b0);
    chk(mem_wr, 1'b0);
    chk(pready, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    skip_cnt = 0;
    issue(OP_INCR_TO_ACCUM_SKIP_IF_NIL, 3'h0, 8'h70, 8'h10, 1'b0);
    chk(working_register, 8'h11);
    apb(1'b0, ADDR_SKIPS, 32'h0);
    chk(r, skip_cnt);
    $display("reset test done");
  endtask : t_rst

  initial begin
    #20000;
    error_cnt++;
    close_out();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {instr_valid, instr_op, instr_bit, instr_addr, mem_rdata} = '0;
    error_cnt = 0;
    samples_checked = 0;
    skip_cnt = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_apb();
    t_incr();
    t_bits();
    t_byte();
    t_sub();
    t_flags();
    t_rst();
    close_out();
  end
endmodule : sasd_datapath_tb_top
